// [design/rbta_pkg.sv]
// Package for the banked ROM table address block: offsets, field layout,
// reset values, timing counts and state encodings.
// Assumes an 8-bit data memory map and a 16-bit wide program ROM.
package rbta_pkg;

    // Table address layout
    localparam int TAB_AW_MAX   = 18;
    localparam int PAGE_W       = 8;
    localparam int PAGE_SEL_W   = 5;
    localparam int BANK_LSB     = 13;
    localparam int BANK_FIELD_W = 5;
    localparam int BANK_WORDS   = 8192;
    localparam int ROM_DW       = 16;
    localparam int BANK_CNT_MAX = 32;

    localparam logic [PAGE_SEL_W-1:0] LAST_PAGE = 5'h1F;

    // Register map, data memory addresses
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam logic [REG_AW-1:0] OFF_PTR_LOW   = 8'h07;
    localparam logic [REG_AW-1:0] OFF_DATA_HIGH = 8'h08;
    localparam logic [REG_AW-1:0] OFF_BANK_SEL  = 8'h2D;
    localparam logic [REG_AW-1:0] OFF_PTR_MID   = 8'h3C;
    localparam logic [REG_AW-1:0] OFF_PTR_HIGH  = 8'h3D;
    localparam logic [REG_AW-1:0] OFF_ACT_BANK  = 8'h3E;

    localparam logic [REG_DW-1:0] RST_BYTE = 8'h00;

    // A table read occupies this many cycles after it is taken
    localparam int TAB_RD_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE  = 2'b10
    } rbta_state_t;

    typedef enum logic {
        MODE_CUR  = 1'b0,
        MODE_LAST = 1'b1
    } rbta_mode_t;

endpackage

// [design/rbta_addr_if.sv]
// Interface between the control logic and the table address former.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/1ps
interface rbta_addr_if;
    import rbta_pkg::*;

    logic [REG_DW-1:0]     ptr_low;
    logic [REG_DW-1:0]     ptr_mid;
    logic [REG_DW-1:0]     ptr_high;
    logic [REG_DW-1:0]     bank;
    rbta_mode_t            mode;
    logic [TAB_AW_MAX-1:0] addr;

    modport former (
        input  ptr_low,
        input  ptr_mid,
        input  ptr_high,
        input  bank,
        input  mode,
        output addr
    );

    modport user (
        output ptr_low,
        output ptr_mid,
        output ptr_high,
        output bank,
        output mode,
        input  addr
    );
endinterface

// [design/rbta_addr_gen.sv]
// Table address former: builds the ROM word address of a table read.
// Assumes pointer and bank inputs are stable registers of the caller.
`timescale 1ns/1ps
module rbta_addr_gen
    import rbta_pkg::*;
#(
    parameter int TAB_AW = 18
) (
    rbta_addr_if.former a
);

    // Clears every bit at or above the given width
    function automatic logic [TAB_AW_MAX-1:0] keep_low(
        input logic [TAB_AW_MAX-1:0] v,
        input int                    w
    );
        logic [TAB_AW_MAX-1:0] r;
        r = '0;
        for (int i = 0; i < TAB_AW_MAX; i++) begin
            if (i < w) begin
                r[i] = v[i];
            end
        end
        return r;
    endfunction

    logic [TAB_AW_MAX-1:0] cur_addr;
    logic [TAB_AW_MAX-1:0] last_addr;
    logic [TAB_AW_MAX-1:0] bank_wide;

    // Upper bank bits past the variant width never reach the address
    assign bank_wide = keep_low({10'h000, a.bank}, TAB_AW - BANK_LSB);

    assign cur_addr = {a.ptr_high[1:0],
                       a.ptr_mid[7:5],
                       a.ptr_mid[4:0],
                       a.ptr_low};

    assign last_addr = {bank_wide[BANK_FIELD_W-1:0],
                        LAST_PAGE,
                        a.ptr_low};

    assign a.addr = keep_low((a.mode == MODE_LAST) ? last_addr : cur_addr,
                             TAB_AW);

endmodule

// [design/rbta_top.sv]
// Banked program ROM table address block with its pointer registers.
// Assumes a same-clock core issuing table reads and a ROM whose data
// answers combinationally to the address shown with rom_rd_o.
//
// Behaviour
// - Current-page address from pointer low, mid, high
// - Address bits 7..0 from pointer low
// - Last-page bank field from bank select bits
// - Table address width is a variant parameter
// - Banks of 8192 words, variant bank count
// - Bank write activates on jump, call, interrupt
// - Bank value n selects words n*2000h upward
// - Eight-bit bank register, low bits effective
// - Bank register at 2Dh, read and write
// - Low byte to destination, high byte latched
// - Last-page read forces bits 12..8 high
// - Table read takes two cycles
`timescale 1ns/1ps
module rbta_top
    import rbta_pkg::*;
#(
    parameter int TAB_AW   = 18,
    parameter int BANK_CNT = 32
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic [REG_AW-1:0]     reg_addr_i,
    input  wire logic [REG_DW-1:0]     reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [REG_DW-1:0]     reg_rdata_o,
    input  wire logic                  tabrd_cur_i,
    input  wire logic                  tabrd_last_i,
    input  wire logic                  branch_done_i,
    output logic                       tab_busy_o,
    output logic                       tab_done_o,
    output logic      [REG_DW-1:0]     tab_low_o,
    output logic      [TAB_AW_MAX-1:0] rom_addr_o,
    output logic                       rom_rd_o,
    input  wire logic [ROM_DW-1:0]     rom_data_i,
    output logic      [REG_DW-1:0]     active_bank_o
);

    // Effective bank bits for the variant
    localparam int BANK_W = TAB_AW - BANK_LSB;
    // A bank count beyond the field is only flagged, never trapped
    localparam logic BANK_FITS = (BANK_CNT <= (1 << BANK_W));

    // Mask of the bank bits this variant really decodes
    logic [REG_DW-1:0] bank_keep;
    for (genvar g = 0; g < REG_DW; g++) begin : g_bank_keep
        assign bank_keep[g] = (g < BANK_W);
    end

    logic        rst_meta_n;
    logic        rst_n;
    rbta_state_t state;
    logic        take;

    logic [REG_DW-1:0] table_ptr_low;
    logic [REG_DW-1:0] table_ptr_mid;
    logic [REG_DW-1:0] table_ptr_high;
    logic [REG_DW-1:0] rom_bank_select;
    logic [REG_DW-1:0] table_data_high;
    logic [REG_DW-1:0] active_bank;

    rbta_addr_if ai ();

    // Register write decode, used by the pointer and bank select processes
    function automatic logic hit(
        input logic              wr,
        input logic [REG_AW-1:0] addr,
        input logic [REG_AW-1:0] off
    );
        return wr && (addr == off);
    endfunction

    // Reset release through two flops
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Software pointer registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            table_ptr_low  <= RST_BYTE;
            table_ptr_mid  <= RST_BYTE;
            table_ptr_high <= RST_BYTE;
        end else begin
            if (hit(reg_wr_i, reg_addr_i, OFF_PTR_LOW)) begin
                table_ptr_low <= reg_wdata_i;
            end
            if (hit(reg_wr_i, reg_addr_i, OFF_PTR_MID)) begin
                table_ptr_mid <= reg_wdata_i;
            end
            if (hit(reg_wr_i, reg_addr_i, OFF_PTR_HIGH)) begin
                table_ptr_high <= reg_wdata_i;
            end
        end
    end

    // Full byte stored so software reads back what it wrote
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rom_bank_select <= RST_BYTE;
        end else if (hit(reg_wr_i, reg_addr_i, OFF_BANK_SEL)) begin
            rom_bank_select <= reg_wdata_i;
        end
    end

    // Bank in use only moves when a branch completes; value n maps to
    // word n*BANK_WORDS once joined above the 13 in-bank bits
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            active_bank <= RST_BYTE;
        end else if (branch_done_i) begin
            active_bank <= rom_bank_select & bank_keep;
        end
    end

    assign active_bank_o = active_bank;

    // Address former sees the live pointers and the bank register
    assign ai.ptr_low  = table_ptr_low;
    assign ai.ptr_mid  = table_ptr_mid;
    assign ai.ptr_high = table_ptr_high;
    assign ai.bank     = rom_bank_select & bank_keep;
    // Last-page request wins when both arrive together
    assign ai.mode     = tabrd_last_i ? MODE_LAST : MODE_CUR;

    rbta_addr_gen #(
        .TAB_AW (TAB_AW)
    ) u_addr_gen (
        .a (ai.former)
    );

    // New reads are refused until the current one has finished
    assign take = (state == ST_IDLE) && (tabrd_cur_i || tabrd_last_i);

    // Table read sequence: take, fetch, done
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    // Done cycle still counts as busy, requests here drop
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Address captured at take so pointer writes cannot tear a read
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rom_addr_o <= '0;
        end else if (take) begin
            rom_addr_o <= ai.addr;
        end
    end

    // Handshake outputs decode the state directly, no extra lag
    assign rom_rd_o   = (state == ST_FETCH);
    assign tab_busy_o = (state != ST_IDLE);
    assign tab_done_o = (state == ST_DONE);

    // ROM word split: low to the destination, high held read-only
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tab_low_o       <= RST_BYTE;
            table_data_high <= RST_BYTE;
        end else if (state == ST_FETCH) begin
            tab_low_o       <= rom_data_i[7:0];
            table_data_high <= rom_data_i[15:8];
        end
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= RST_BYTE;
        end else if (reg_rd_i) begin
            // Unmapped addresses read back as zero
            case (reg_addr_i)
                OFF_PTR_LOW:   reg_rdata_o <= table_ptr_low;
                OFF_DATA_HIGH: reg_rdata_o <= table_data_high;
                OFF_BANK_SEL:  reg_rdata_o <= rom_bank_select;
                OFF_PTR_MID:   reg_rdata_o <= table_ptr_mid;
                OFF_PTR_HIGH:  reg_rdata_o <= table_ptr_high;
                OFF_ACT_BANK:  reg_rdata_o <= active_bank;
                default:       reg_rdata_o <= RST_BYTE;
            endcase
        end else begin
            reg_rdata_o <= RST_BYTE;
        end
    end

    // BANK_CNT kept for variant bookkeeping; counts of 24 and 12 share
    // the bit width of 32 and 16, so out-of-range banks are not trapped
    logic unused_cnt;
    assign unused_cnt = (BANK_CNT > BANK_CNT_MAX) || !BANK_FITS;

endmodule

// [verification/rbta_rom_model.sv]
// Behavioural program ROM on the far side of the table address block.
// Assumes the word answers combinationally while the read strobe is high.
`timescale 1ns/1ps
module rbta_rom_model
    import rbta_pkg::*;
(
    input  wire logic [TAB_AW_MAX-1:0] addr_i,
    input  wire logic                  rd_i,
    output logic      [ROM_DW-1:0]     data_o
);
    logic [ROM_DW-1:0] word;
    // Word derived from the address so a slipped bit shows
    assign word = {addr_i[15:8] ^ 8'h3C, addr_i[7:0] ^ 8'hC3};
    // Inverted when idle, so a stale sample never looks right
    assign data_o = rd_i ? word : ~word;
endmodule

// [verification/rbta_monitor.sv]
// Checker for the table address block, bound to its top ports.
// Assumes the bind hands on the address width of the instance.
`timescale 1ns/1ps
module rbta_monitor
    import rbta_pkg::*;
#(
    parameter int TAB_AW = 18
) (
    input wire logic                  core_clk_i,
    input wire logic                  arst_n_i,
    input wire logic                  reg_rd_i,
    input wire logic [REG_DW-1:0]     reg_rdata_o,
    input wire logic                  tabrd_cur_i,
    input wire logic                  tabrd_last_i,
    input wire logic                  branch_done_i,
    input wire logic                  tab_busy_o,
    input wire logic                  tab_done_o,
    input wire logic [REG_DW-1:0]     tab_low_o,
    input wire logic [TAB_AW_MAX-1:0] rom_addr_o,
    input wire logic                  rom_rd_o,
    input wire logic [ROM_DW-1:0]     rom_data_i,
    input wire logic [REG_DW-1:0]     active_bank_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence take_s;
        (tabrd_cur_i || tabrd_last_i) && !tab_busy_o;
    endsequence
    sequence walk_s;
        rom_rd_o && tab_busy_o ##1 tab_done_o && !rom_rd_o ##1 !tab_busy_o;
    endsequence
    a_table_two_cycles: assert property (take_s |=> walk_s)
        else $error("table read timing wrong");
    a_last_page_ones: assert property (tabrd_last_i && !tab_busy_o
        |=> rom_addr_o[12:8] == LAST_PAGE) else $error("last page bits");
    a_low_byte_path: assert property (tab_done_o
        |-> tab_low_o == $past(rom_data_i[7:0])) else $error("low byte");
    a_addr_holds: assert property (rom_rd_o |=> $stable(rom_addr_o))
        else $error("address moved during read");
    a_addr_width_cut: assert property ((rom_addr_o >> TAB_AW) == 18'h0)
        else $error("address bit above width");
    a_bank_mask_cut: assert property
        ((active_bank_o >> (TAB_AW - BANK_LSB)) == 8'h00)
        else $error("bank bit above effective width");
    a_bank_holds: assert property (!branch_done_i
        |=> $stable(active_bank_o)) else $error("bank changed early");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind rbta_top rbta_monitor #(.TAB_AW(TAB_AW)) u_mon (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tabrd_cur_i(tabrd_cur_i),
    .tabrd_last_i(tabrd_last_i), .branch_done_i(branch_done_i),
    .tab_busy_o(tab_busy_o), .tab_done_o(tab_done_o),
    .tab_low_o(tab_low_o), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
    .rom_data_i(rom_data_i), .active_bank_o(active_bank_o));

// [verification/testbench.sv]
// Self-checking bench for the table address block and its registers.
// Assumes a 17-bit variant with 16 banks and a behavioural ROM.
`timescale 1ns/1ps
module testbench;
    import rbta_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        arst_n_i   = 1'b0;
    logic [7:0]  ra = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cur = 1'b0;
    logic        last = 1'b0;
    logic        br = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  low;
    logic [7:0]  act;
    logic        busy;
    logic        done;
    logic        rrd;
    logic [17:0] addr;
    logic [15:0] rom;
    int          fail_count = 0;
    int          compares = 0;

    always #10 core_clk_i = ~core_clk_i;

    rbta_top #(.TAB_AW(17), .BANK_CNT(16)) dut (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(ra),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .tabrd_cur_i(cur), .tabrd_last_i(last), .branch_done_i(br),
        .tab_busy_o(busy), .tab_done_o(done), .tab_low_o(low),
        .rom_addr_o(addr), .rom_rd_o(rrd), .rom_data_i(rom),
        .active_bank_o(act));
    rbta_rom_model rom_m (.addr_i(addr), .rd_i(rrd), .data_o(rom));

    task automatic chk(input string n, input logic [17:0] e,
                       input logic [17:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Each access ends with an idle cycle so no strobe is set twice at once
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        ra <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 chk("reg_rdata", {10'h0, e}, {10'h0, rdata});
        @(posedge core_clk_i);
    endtask
    task automatic brn(input logic [7:0] e);
        br <= 1'b1;
        @(posedge core_clk_i);
        br <= 1'b0;
        #1 chk("active_bank", {10'h0, e}, {10'h0, act});
        @(posedge core_clk_i);
    endtask
    task automatic tab(input logic l, input logic c, input logic [17:0] ea);
        logic [15:0] w;
        w = {ea[15:8] ^ 8'h3C, ea[7:0] ^ 8'hC3};
        last <= l;
        cur <= c;
        @(posedge core_clk_i);
        last <= 1'b0;
        cur <= 1'b0;
        #1 chk("rom_addr", ea, addr);
        @(posedge core_clk_i);
        #1 chk("tab_done", 18'h1, {17'h0, done});
        chk("tab_low", {10'h0, w[7:0]}, {10'h0, low});
        @(posedge core_clk_i);
        rreg(OFF_DATA_HIGH, w[15:8]);
    endtask
    task automatic report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge core_clk_i);
        fail_count++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        report_and_stop();
    end

    initial begin
        logic [7:0] map [7];
        map = '{8'h2D, 8'h07, 8'h3C, 8'h3D, 8'h08, 8'h3E, 8'h55};
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        foreach (map[i]) rreg(map[i], 8'h00);
        wreg(OFF_DATA_HIGH, 8'h77);
        rreg(OFF_DATA_HIGH, 8'h00);
        $display("test reset and map done");
        wreg(OFF_BANK_SEL, 8'hFF);
        rreg(OFF_BANK_SEL, 8'hFF);
        chk("active_bank", 18'h0, {10'h0, act});
        brn(8'h0F);
        rreg(OFF_ACT_BANK, 8'h0F);
        wreg(OFF_BANK_SEL, 8'h01);
        chk("active_bank", 18'hF, {10'h0, act});
        brn(8'h01);
        $display("test bank switch done");
        wreg(OFF_PTR_LOW, 8'hA5);
        wreg(OFF_PTR_MID, 8'hE3);
        wreg(OFF_PTR_HIGH, 8'hFF);
        tab(1'b0, 1'b1, 18'h1E3A5);
        $display("test current page done");
        tab(1'b1, 1'b1, 18'h03FA5);
        wreg(OFF_BANK_SEL, 8'hFF);
        tab(1'b1, 1'b0, 18'h1FFA5);
        wreg(OFF_PTR_LOW, 8'h06);
        tab(1'b1, 1'b0, 18'h1FF06);
        $display("test last page done");
        report_and_stop();
    end
endmodule
